// ---- bod_core.sv ----
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Pattern 0011 11df ffff increments the file register, flags untouched.
// - Increment result goes to accumulator if d is 0, file if 1.
// - Zero increment result discards the prefetched word, runs an idle slot.
// - Pattern 0000 10df ffff computes file minus accumulator, sets carry, half borrow, zero.
// - Difference goes to accumulator if d is 0, file if 1.
// - Pattern 0011 10df ffff swaps the two nibbles, flags untouched.
// - Swapped byte goes to accumulator if d is 0, file if 1.
// - Pattern 0000 0000 0fff loads accumulator into a direction register.
// - Instruction cycle is four clock periods; skips take two cycles.
// - Low five bits address the file, bit 5 selects destination.
module bod_core
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [11:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    output logic [4:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic file_we_o,
    output logic [7:0] acc_o,
    output logic [2:0] flags_o,
    output logic flush_o,
    output logic cycle_end_o,
    output logic idle_o,
    output logic illegal_dir_o,
    output logic [7:0] dir_5_o,
    output logic [7:0] dir_6_o,
    output logic [7:0] dir_7_o,
    output logic [7:0] dir_8_o,
    output logic [7:0] dir_9_o
);
    import bod_pkg::*;

    typedef enum logic [1:0]
    {
        BOD_ST_Q1 = 2'b00,
        BOD_ST_Q2 = 2'b01,
        BOD_ST_Q3 = 2'b11,
        BOD_ST_Q4 = 2'b10
    } bod_phase_t;

    typedef struct packed
    {
        bod_phase_t phase;
        logic [11:0] ir;
        logic skip_pend;
        logic idle;
        logic [7:0] acc;
        logic [2:0] flags;
        logic [4:0] faddr;
        logic [7:0] fwdata;
        logic fwe;
        logic flush;
        logic cyc_end;
        logic bad_dir;
        logic [BOD_DIR_COUNT-1:0][7:0] dir;
    } bod_state_t;

    bod_state_t st_r;
    bod_state_t st_nxt;
    logic [5:0] opc;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_h;
    logic alu_z;
    logic [3:0] dir_sel;
    logic [3:0] dir_idx;
    logic is_inc;
    logic is_sub;
    logic is_swap;
    logic is_dir;

    // ----------------------------------------------------------------
    // Field split and datapath
    // ----------------------------------------------------------------
    // Idle slot executes as the all-ones opcode 6'h3f with no effect
    assign opc = st_r.idle ? 6'h3f : st_r.ir[BOD_OPC_MSB:BOD_OPC_LSB];
    assign dir_sel = {1'b0, st_r.ir[BOD_DIRSEL_MSB:0]};
    assign dir_idx = dir_sel - BOD_DIR_SEL_MIN;

    // Opcode decode; Q4 ignores all of it during an idle slot
    assign is_inc = (opc == BOD_OPC_INC_SKIP);
    assign is_sub = (opc == BOD_OPC_SUB);
    assign is_swap = (opc == BOD_OPC_SWAP);
    assign is_dir = (st_r.ir[BOD_OPC_MSB:BOD_DIRL_LSB] == BOD_OPC_DIR_LOAD);

    bod_alu u_alu
    (
        .opc_i(opc),
        .file_i(file_rdata_i),
        .acc_i(st_r.acc),
        .result_o(alu_res),
        .carry_o(alu_c),
        .half_o(alu_h),
        .zero_o(alu_z)
    );

    // ----------------------------------------------------------------
    // Phase sequencer and execute
    // ----------------------------------------------------------------
    // Fetch at Q1, read file in Q2, commit results at Q4
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fwe = 1'b0;
        st_nxt.flush = 1'b0;
        st_nxt.cyc_end = 1'b0;
        st_nxt.bad_dir = 1'b0;
        case (st_r.phase)
            BOD_ST_Q1:
            begin
                // Prefetched word dropped when a skip is pending
                st_nxt.idle = st_r.skip_pend;
                st_nxt.ir = st_r.skip_pend ? BOD_IDLE_WORD : instr_i;
                st_nxt.skip_pend = 1'b0;
                st_nxt.phase = BOD_ST_Q2;
            end
            BOD_ST_Q2:
            begin
                st_nxt.faddr = st_r.ir[BOD_FADDR_MSB:0];
                st_nxt.phase = BOD_ST_Q3;
            end
            BOD_ST_Q3:
            begin
                st_nxt.phase = BOD_ST_Q4;
            end
            BOD_ST_Q4:
            begin
                st_nxt.phase = BOD_ST_Q1;
                st_nxt.cyc_end = 1'b1;
                if (!st_r.idle)
                begin
                    if (is_inc || is_sub || is_swap)
                    begin
                        // Destination select
                        if (st_r.ir[BOD_DEST_BIT])
                        begin
                            st_nxt.fwdata = alu_res;
                            st_nxt.fwe = 1'b1;
                        end
                        else
                        begin
                            st_nxt.acc = alu_res;
                        end
                    end
                    if (is_sub)
                    begin
                        st_nxt.flags[BOD_FLAG_CARRY] = alu_c;
                        st_nxt.flags[BOD_FLAG_HALF] = alu_h;
                        st_nxt.flags[BOD_FLAG_ZERO] = alu_z;
                    end
                    if (is_inc && alu_z)
                    begin
                        st_nxt.skip_pend = 1'b1;
                        st_nxt.flush = 1'b1;
                    end
                    if (is_dir)
                    begin
                        // Three-bit selector: registers 8 and 9 keep their reset value
                        // Selectors outside 5..9 leave all registers alone
                        if (dir_sel >= BOD_DIR_SEL_MIN && dir_sel <= BOD_DIR_SEL_MAX)
                        begin
                            st_nxt.dir[dir_idx[2:0]] = st_r.acc;
                        end
                        else
                        begin
                            st_nxt.bad_dir = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                st_nxt.phase = BOD_ST_Q1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_r <= '0;
            st_r.phase <= BOD_ST_Q1;
            st_r.acc <= BOD_ACC_RESET;
            st_r.dir <= {BOD_DIR_COUNT{BOD_DIR_RESET}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign file_addr_o = st_r.faddr;
    assign file_wdata_o = st_r.fwdata;
    assign file_we_o = st_r.fwe;
    assign acc_o = st_r.acc;
    assign flags_o = st_r.flags;
    assign flush_o = st_r.flush;
    assign cycle_end_o = st_r.cyc_end;
    assign idle_o = st_r.idle;
    assign illegal_dir_o = st_r.bad_dir;
    assign dir_5_o = st_r.dir[0];
    assign dir_6_o = st_r.dir[1];
    assign dir_7_o = st_r.dir[2];
    assign dir_8_o = st_r.dir[3];
    assign dir_9_o = st_r.dir[4];

endmodule
`default_nettype wire

// ---- bod_pkg.sv ----
package bod_pkg;

    // ----------------------------------------------------------------
    // Instruction encodings
    // ----------------------------------------------------------------
    localparam logic [5:0] BOD_OPC_INC_SKIP = 6'h0f; // 0011 11
    localparam logic [5:0] BOD_OPC_SUB = 6'h02; // 0000 10
    localparam logic [5:0] BOD_OPC_SWAP = 6'h0e; // 0011 10
    localparam logic [8:0] BOD_OPC_DIR_LOAD = 9'h000; // 0000 0000 0
    localparam int BOD_OPC_MSB = 11;
    localparam int BOD_OPC_LSB = 6;
    localparam int BOD_DEST_BIT = 5;
    localparam int BOD_FADDR_MSB = 4;
    localparam int BOD_DIRSEL_MSB = 2;
    localparam int BOD_DIRL_LSB = 3;

    // ----------------------------------------------------------------
    // Direction register selectors
    // ----------------------------------------------------------------
    localparam logic [3:0] BOD_DIR_SEL_MIN = 4'h5;
    localparam logic [3:0] BOD_DIR_SEL_MAX = 4'h9;
    localparam int BOD_DIR_COUNT = 5;

    // ----------------------------------------------------------------
    // Timing and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] BOD_PHASES_PER_CYCLE_M1 = 2'h3; // four periods
    localparam logic [7:0] BOD_DIR_RESET = 8'hff;
    localparam logic [7:0] BOD_ACC_RESET = 8'h00;
    localparam logic [11:0] BOD_IDLE_WORD = 12'h000;

    // Flag positions in the status byte
    localparam int BOD_FLAG_CARRY = 0;
    localparam int BOD_FLAG_HALF = 1;
    localparam int BOD_FLAG_ZERO = 2;

endpackage

// ---- bod_alu.sv ----
`timescale 1ns/1ps
`default_nettype none

module bod_alu
(
    input wire logic [5:0] opc_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] acc_i,
    output logic [7:0] result_o,
    output logic carry_o,
    output logic half_o,
    output logic zero_o
);
    import bod_pkg::*;

    logic [8:0] diff;
    logic [4:0] ldiff;

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    // Borrow-free subtract keeps carry high on a non-negative result
    always_comb
    begin
        diff = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
        ldiff = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
        carry_o = diff[8];
        half_o = ldiff[4];
        case (opc_i)
            BOD_OPC_INC_SKIP: result_o = file_i + 8'h01;
            BOD_OPC_SUB: result_o = diff[7:0];
            BOD_OPC_SWAP: result_o = {file_i[3:0], file_i[7:4]};
            default: result_o = file_i;
        endcase
        zero_o = (result_o == 8'h00);
    end

endmodule
`default_nettype wire

// ---- bod_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module bod_core_sva
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [4:0] file_addr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic file_we_o,
    input wire logic [7:0] acc_o,
    input wire logic [2:0] flags_o,
    input wire logic flush_o,
    input wire logic cycle_end_o,
    input wire logic idle_o,
    input wire logic illegal_dir_o,
    input wire logic [7:0] dir_5_o,
    input wire logic [7:0] dir_6_o,
    input wire logic [7:0] dir_7_o,
    input wire logic [7:0] dir_8_o,
    input wire logic [7:0] dir_9_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // Reachable direction registers viewed as one word
    wire logic [23:0] dir_w = {dir_5_o, dir_6_o, dir_7_o};
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_period; cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o; endproperty
    property p_skip; flush_o |-> cycle_end_o && (file_we_o ? !file_wdata_o : !acc_o); endproperty
    property p_idle; flush_o |=> idle_o [*4] ##1 !idle_o; endproperty
    property p_quiet; idle_o && cycle_end_o |-> !file_we_o && !flush_o && $stable(acc_o); endproperty
    property p_flags; $changed(flags_o) |-> cycle_end_o && !idle_o; endproperty
    property p_acc; $changed(acc_o) |-> cycle_end_o && !file_we_o; endproperty
    property p_dir; $changed(dir_w) |-> cycle_end_o && !file_we_o && !illegal_dir_o; endproperty
    property p_ill; illegal_dir_o |-> cycle_end_o && $stable(dir_w) && $stable(acc_o); endproperty
    property p_unreach; dir_8_o == 8'hff && dir_9_o == 8'hff; endproperty
    property p_addr; file_we_o |-> $stable(file_addr_o); endproperty
    a_period: assert property (p_period) else $error("cycle end spacing wrong");
    a_skip: assert property (p_skip) else $error("flush without zero result");
    a_idle: assert property (p_idle) else $error("idle slot length wrong");
    a_quiet: assert property (p_quiet) else $error("idle slot had an effect");
    a_flags: assert property (p_flags) else $error("flags moved off commit");
    a_acc: assert property (p_acc) else $error("acc moved wrongly");
    a_dir: assert property (p_dir) else $error("direction moved wrongly");
    a_ill: assert property (p_ill) else $error("refused load had effect");
    a_unreach: assert property (p_unreach) else $error("unreachable dir changed");
    a_addr: assert property (p_addr) else $error("address moved at write");
    c_flush: cover property (flush_o);
    c_ill: cover property (illegal_dir_o);
    c_we: cover property (file_we_o);
endmodule
bind bod_core bod_core_sva chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
    .acc_o(acc_o), .flags_o(flags_o), .flush_o(flush_o), .cycle_end_o(cycle_end_o),
    .idle_o(idle_o), .illegal_dir_o(illegal_dir_o), .dir_5_o(dir_5_o), .dir_6_o(dir_6_o),
    .dir_7_o(dir_7_o), .dir_8_o(dir_8_o), .dir_9_o(dir_9_o));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bod_pkg::*;
    localparam logic [11:0] FILL = 12'hfff; // Unused opcode, no effect
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [11:0] instr_i = FILL;
    logic [7:0] file_rdata_i = 8'h00;
    logic [4:0] file_addr_o;
    logic [7:0] file_wdata_o, acc_o, dir_5_o, dir_6_o, dir_7_o, dir_8_o, dir_9_o;
    logic [2:0] flags_o;
    logic file_we_o, flush_o, cycle_end_o, idle_o, illegal_dir_o;
    int err_count = 0;
    int checks = 0;
    // Reference state kept by the bench
    logic [7:0] m_acc = 8'h00;
    logic [2:0] m_flg = 3'h0;
    logic [7:0] m_dir [5:7] = '{default: 8'hff};
    bod_core dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
        .file_we_o(file_we_o), .acc_o(acc_o), .flags_o(flags_o), .flush_o(flush_o),
        .cycle_end_o(cycle_end_o), .idle_o(idle_o), .illegal_dir_o(illegal_dir_o),
        .dir_5_o(dir_5_o), .dir_6_o(dir_6_o), .dir_7_o(dir_7_o), .dir_8_o(dir_8_o),
        .dir_9_o(dir_9_o));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One instruction plus a filler slot; nw is the word fetched behind it
    task exec(input logic [11:0] w, input logic [7:0] f, input logic [11:0] nw);
        logic [7:0] r;
        logic dl, ill, we, skip;
        r = (w[11:6] == BOD_OPC_SUB) ? f - m_acc : (w[11:6] == BOD_OPC_SWAP) ? {f[3:0], f[7:4]} : f + 8'h01;
        skip = (w[11:6] == BOD_OPC_INC_SKIP) && (r == 8'h00);
        dl = (w[11:3] == BOD_OPC_DIR_LOAD);
        ill = dl && (w[2:0] < 3'h5);
        we = !dl && w[5];
        if (w[11:6] == BOD_OPC_SUB) m_flg = {r == 8'h00, f[3:0] >= m_acc[3:0], f >= m_acc};
        instr_i <= w;
        file_rdata_i <= f;
        // Filler slot behind the last call has committed; a word that was
        // not discarded after a zero increment would show up here
        @(negedge core_clk_i);
        chk(acc_o, m_acc);
        repeat (4) @(posedge core_clk_i);
        instr_i <= nw;
        if (dl && !ill) m_dir[w[2:0]] = m_acc;
        if (!dl && !w[5]) m_acc = r;
        @(negedge core_clk_i);
        chk(acc_o, m_acc);
        chk(flags_o, m_flg);
        chk({file_we_o, file_addr_o}, {we, w[4:0]});
        if (we) chk(file_wdata_o, r);
        chk({cycle_end_o, flush_o, illegal_dir_o}, {1'b1, skip, ill});
        chk({dir_5_o, dir_6_o, dir_7_o}, {m_dir[5], m_dir[6], m_dir[7]});
        chk({dir_8_o, dir_9_o}, 16'hffff);
        @(negedge core_clk_i);
        chk(idle_o, skip);
        repeat (3) @(posedge core_clk_i);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_swap;
        exec({BOD_OPC_SWAP, 1'b0, 5'h1f}, 8'ha5, FILL);
        exec({BOD_OPC_SWAP, 1'b1, 5'h00}, 8'h3c, FILL);
        $display("test swap done");
    endtask
    // Borrow, no borrow, half borrow only, zero
    task t_sub;
        logic [7:0] fv [4] = '{8'h01, 8'h03, 8'h10, 8'h02};
        exec({BOD_OPC_SWAP, 1'b0, 5'h02}, 8'h20, FILL);
        for (int i = 0; i < 4; i++) exec({BOD_OPC_SUB, 1'(i != 3), 5'(i + 3)}, fv[i], FILL);
        $display("test sub done");
    endtask
    // Word behind a zero increment would change acc if not discarded
    task t_inc;
        exec({BOD_OPC_INC_SKIP, 1'b0, 5'h04}, 8'h10, FILL);
        exec({BOD_OPC_INC_SKIP, 1'b1, 5'h05}, 8'hff, {BOD_OPC_SWAP, 1'b0, 5'h05});
        exec({BOD_OPC_INC_SKIP, 1'b0, 5'h06}, 8'hff, {BOD_OPC_SWAP, 1'b0, 5'h06});
        $display("test inc done");
    endtask
    task t_dir;
        for (int s = 0; s < 8; s++)
        begin
            exec({BOD_OPC_SWAP, 1'b0, 5'h07}, 8'(s + 16), FILL);
            exec({BOD_OPC_DIR_LOAD, 3'(s)}, 8'h00, FILL);
        end
        $display("test dir done");
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Clock, reset and main sequence
    initial forever #20 core_clk_i = ~core_clk_i;
    initial
    begin
        repeat (10) @(posedge core_clk_i);
        srst_i <= 1'b0;
        t_swap();
        t_sub();
        t_inc();
        t_dir();
        end_of_test();
    end
    // About 220 cycles expected; allow several times that
    initial
    begin
        #80000;
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
